// ### design/rst_pwr_regs.svh
`ifndef RST_PWR_REGS_SVH
`define RST_PWR_REGS_SVH

// register byte offsets
`define OFS_CONTROL          16'h0000
`define OFS_EVENT_STATUS     16'h0004
`define OFS_EVENT_MASK       16'h0008
`define OFS_STATE            16'h000C
`define OFS_REGULATOR_POWER  16'h00D0

// control fields
`define CTRL_PIN_MODE_BIT    0
`define CTRL_RESET           32'h0000_0000

// event status / mask bit positions
`define EVT_SLEEP_ENTER_BIT  0
`define EVT_SLEEP_EXIT_BIT   1
`define EVT_RESET_DONE_BIT   2
`define EVT_EXT_LSB          3
`define MASK_RESET           32'h0000_0000

// state register fields
`define STATE_SLEEP_BIT      0
`define STATE_PIN_BIT        1
`define STATE_LONG_RST_BIT   2
`define STATE_STRAP_LSB      8

// regulator control
`define REG_OFF_BIT          0
`define REGULATOR_RESET      16'h0000

// timing
`define CLK_PERIOD_NS        50
`define RST_HOLD_MIN_NS      1000
`define RST_HOLD_MIN_CYC \
    ((`RST_HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_RELEASE_CYC      4
`define TRST_SYNC_STAGES     2

`endif

// ### design/rst_pwr_pkg.sv
package rst_pwr_pkg;

    typedef enum logic [1:0] {
        RST_HELD,
        RST_RELEASE,
        RST_RUN
    } rst_state_e;

    typedef enum logic {
        PIN_SLEEP_IN = 1'b0,
        PIN_IRQ_OUT  = 1'b1
    } pin_mode_e;

endpackage

// ### design/test_reset_sync.sv
`timescale 1ns/1ns

module test_reset_sync #(
    parameter int STAGES = 2
) (
    // clock and resets
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic trst_n,
    // synchronised test reset
    output logic      test_logic_reset
);

    logic [STAGES-1:0] chain;

    // assertion is asynchronous so test logic clears with no clock at all
    always_ff @(posedge clk_sys or posedge reset or negedge trst_n) begin
        if (reset || !trst_n) begin
            chain <= '1;
        end else begin
            chain <= {chain[STAGES-2:0], 1'b0};
        end
    end

    assign test_logic_reset = chain[STAGES-1];

endmodule // test_reset_sync

// ### design/strap_capture.sv
`timescale 1ns/1ns

module strap_capture #(
    parameter int              WIDTH   = 5,
    parameter logic [WIDTH-1:0] DEFAULT = '0
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset,
    // capture control
    input  wire logic             capture,
    input  wire logic [WIDTH-1:0] strap_pins,
    // latched options
    output logic      [WIDTH-1:0] strap_cfg
);

    // follows the pins while capture is high, frozen once it drops; reset loads DEFAULT
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            strap_cfg <= DEFAULT;
        end else if (capture) begin
            strap_cfg <= strap_pins;
        end
    end

endmodule // strap_capture

// ### design/reset_powerdown_interrupt_pin.sv
// Our own choice: register access over APB.
`timescale 1ns/1ns
`include "rst_pwr_regs.svh"

// How it works
// - hardware reset pin low returns every software register to its default value
// - every hardware reset also re-establishes the strap options
// - shared pin is a sleep input after reset; a register makes it interrupt
// - in sleep configuration, pin driven low puts device in power-down
// - in interrupt configuration, pin is pulled low open-drain while irq pends
// - test reset is active low and asynchronous, independent of test clock
// - regulator register request shuts off regulator when core fed externally
// - strap pin levels are sampled while reset is asserted

module reset_powerdown_interrupt_pin #(
    parameter int             STRAP_W     = 5,
    parameter logic [4:0]     STRAP_DEF   = 5'h01,
    parameter int             EXT_EVT_W   = 5
) (
    // system
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic      [31:0]          prdata,
    output logic                      pslverr,
    // reset pins
    input  wire logic                 hw_reset_n,
    input  wire logic                 trst_n,
    input  wire logic [STRAP_W-1:0]   strap_pins,
    // shared open-drain pin
    input  wire logic                 irq_or_sleep_pin_in,
    output logic                      irq_or_sleep_pin_out,
    output logic                      irq_or_sleep_pin_oe,
    // core side
    input  wire logic [EXT_EVT_W-1:0] phy_event,
    input  wire logic                 ext_core_supply,
    output logic                      core_reset,
    output logic                      test_logic_reset,
    output logic      [STRAP_W-1:0]   strap_cfg,
    output logic                      power_down,
    output logic                      regulator_off,
    output logic                      irq
);

    ////////////////////////////////////////////////////////////////////////

    localparam int NEVT    = `EVT_EXT_LSB + EXT_EVT_W;
    localparam int HOLD_W  = $clog2(`RST_HOLD_MIN_CYC + 1);
    localparam int REL_W   = $clog2(`RST_RELEASE_CYC + 1);

    localparam logic [HOLD_W-1:0] HOLD_MIN =
        HOLD_W'(`RST_HOLD_MIN_CYC);
    localparam logic [REL_W-1:0]  REL_LAST =
        REL_W'(`RST_RELEASE_CYC - 1);

    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] ofs);
        return {a[15:2], 2'b00} == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer

    rst_pwr_pkg::rst_state_e state;
    rst_pwr_pkg::rst_state_e next_state;
    logic [REL_W-1:0]        rel_cnt;
    logic [HOLD_W-1:0]       hold_cnt;
    logic                    long_reset;
    logic                    reset_done;

    always_comb begin
        next_state = state;
        unique case (state)
            rst_pwr_pkg::RST_HELD: begin
                if (hw_reset_n) begin
                    next_state = rst_pwr_pkg::RST_RELEASE;
                end
            end
            rst_pwr_pkg::RST_RELEASE: begin
                if (!hw_reset_n) begin
                    next_state = rst_pwr_pkg::RST_HELD;
                end else if (rel_cnt == REL_LAST) begin
                    next_state = rst_pwr_pkg::RST_RUN;
                end
            end
            rst_pwr_pkg::RST_RUN: begin
                if (!hw_reset_n) begin
                    next_state = rst_pwr_pkg::RST_HELD;
                end
            end
            default: next_state = rst_pwr_pkg::RST_HELD;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= rst_pwr_pkg::RST_HELD;
        end else begin
            state <= next_state;
        end
    end

    // release is counted so the core sees a clean, clock-aligned edge
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rel_cnt <= '0;
        end else if (state == rst_pwr_pkg::RST_RELEASE) begin
            rel_cnt <= rel_cnt + REL_W'(1);
        end else begin
            rel_cnt <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= next_state != rst_pwr_pkg::RST_RUN;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reset_done <= 1'b0;
        end else begin
            reset_done <= state == rst_pwr_pkg::RST_RELEASE &&
                          next_state == rst_pwr_pkg::RST_RUN;
        end
    end

    // shorter pulses still reset; software can see whether the last
    // pulse was long enough to be trusted by the analog side
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            hold_cnt <= '0;
        end else if (!hw_reset_n) begin
            if (hold_cnt != HOLD_MIN) begin
                hold_cnt <= hold_cnt + HOLD_W'(1);
            end
        end else if (state == rst_pwr_pkg::RST_RUN) begin
            hold_cnt <= '0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            long_reset <= 1'b0;
        end else if (reset_done) begin
            long_reset <= hold_cnt == HOLD_MIN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // straps and test reset

    strap_capture #(
        .WIDTH      (STRAP_W),
        .DEFAULT    (STRAP_W'(STRAP_DEF))
    ) u_straps (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .capture    (state == rst_pwr_pkg::RST_HELD),
        .strap_pins (strap_pins),
        .strap_cfg  (strap_cfg)
    );

    test_reset_sync #(
        .STAGES           (`TRST_SYNC_STAGES)
    ) u_trst (
        .clk_sys          (clk_sys),
        .reset            (reset),
        .trst_n           (trst_n),
        .test_logic_reset (test_logic_reset)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb slave: no wait states, read data prepared in the setup cycle

    logic                         setup;
    logic                         wr_en;
    logic                         known;
    logic [31:0]                  rd_word;
    rst_pwr_pkg::pin_mode_e       pin_mode;
    logic [NEVT-1:0]              evt_status;
    logic [NEVT-1:0]              evt_mask;
    logic [15:0]                  regulator_power_control;
    logic                         sleep_active;
    logic                         irq_pending;

    assign setup = psel && !penable && !pready;
    assign wr_en = psel && penable && pready && pwrite;
    assign known = hit(paddr, `OFS_CONTROL) ||
                   hit(paddr, `OFS_EVENT_STATUS) ||
                   hit(paddr, `OFS_EVENT_MASK) ||
                   hit(paddr, `OFS_STATE) ||
                   hit(paddr, `OFS_REGULATOR_POWER);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit(paddr, `OFS_CONTROL)) begin
            rd_word[`CTRL_PIN_MODE_BIT] = pin_mode;
        end else if (hit(paddr, `OFS_EVENT_STATUS)) begin
            rd_word[NEVT-1:0] = evt_status;
        end else if (hit(paddr, `OFS_EVENT_MASK)) begin
            rd_word[NEVT-1:0] = evt_mask;
        end else if (hit(paddr, `OFS_STATE)) begin
            rd_word[`STATE_SLEEP_BIT]    = sleep_active;
            rd_word[`STATE_PIN_BIT]      = irq_or_sleep_pin_in;
            rd_word[`STATE_LONG_RST_BIT] = long_reset;
            rd_word[`STATE_STRAP_LSB +: STRAP_W] = strap_cfg;
        end else if (hit(paddr, `OFS_REGULATOR_POWER)) begin
            rd_word[15:0] = regulator_power_control;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr <= !known;
        end else if (pready) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers, all cleared while the core is held

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_mode <= rst_pwr_pkg::PIN_SLEEP_IN;
        end else if (core_reset) begin
            pin_mode <= rst_pwr_pkg::PIN_SLEEP_IN;
        end else if (wr_en && hit(paddr, `OFS_CONTROL)) begin
            pin_mode <= rst_pwr_pkg::pin_mode_e'(
                pwdata[`CTRL_PIN_MODE_BIT]);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            evt_mask <= NEVT'(`MASK_RESET);
        end else if (core_reset) begin
            evt_mask <= NEVT'(`MASK_RESET);
        end else if (wr_en && hit(paddr, `OFS_EVENT_MASK)) begin
            evt_mask <= pwdata[NEVT-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regulator_power_control <= `REGULATOR_RESET;
        end else if (core_reset) begin
            regulator_power_control <= `REGULATOR_RESET;
        end else if (wr_en && hit(paddr, `OFS_REGULATOR_POWER)) begin
            regulator_power_control <= pwdata[15:0];
        end
    end

    // regulator stays on unless the core really has its own supply
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regulator_off <= 1'b0;
        end else begin
            regulator_off <= regulator_power_control[`REG_OFF_BIT] &&
                             ext_core_supply;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shared pin and power-down

    logic next_sleep;
    logic [NEVT-1:0] evt_set;

    // judged on the next state so power-down drops at the very edge that
    // raises core_reset; our own open-drain pull is never a sleep request
    assign next_sleep = next_state == rst_pwr_pkg::RST_RUN &&
                        !irq_or_sleep_pin_oe &&
                        pin_mode == rst_pwr_pkg::PIN_SLEEP_IN &&
                        !irq_or_sleep_pin_in;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sleep_active <= 1'b0;
            power_down   <= 1'b0;
        end else begin
            sleep_active <= next_sleep;
            power_down   <= next_sleep;
        end
    end

    // only ever pulls low; the level high comes from the pull-up
    assign irq_or_sleep_pin_out = 1'b0;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq_or_sleep_pin_oe <= 1'b0;
        end else begin
            irq_or_sleep_pin_oe <= next_state == rst_pwr_pkg::RST_RUN &&
                irq_pending && pin_mode == rst_pwr_pkg::PIN_IRQ_OUT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events and interrupt

    always_comb begin
        evt_set = '0;
        evt_set[`EVT_SLEEP_ENTER_BIT] = next_sleep && !sleep_active;
        evt_set[`EVT_SLEEP_EXIT_BIT]  = !next_sleep && sleep_active;
        evt_set[`EVT_RESET_DONE_BIT]  = reset_done;
        evt_set[`EVT_EXT_LSB +: EXT_EVT_W] = phy_event;
    end

    // a new event in the clearing cycle survives the write-one-to-clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            evt_status <= '0;
        end else if (core_reset) begin
            evt_status <= '0;
        end else if (wr_en && hit(paddr, `OFS_EVENT_STATUS)) begin
            evt_status <= (evt_status & ~pwdata[NEVT-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    assign irq_pending = |(evt_status & evt_mask);

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_pending;
        end
    end

endmodule // reset_powerdown_interrupt_pin

// ### verification/host_pin_model.sv
`timescale 1ns/1ns

// board side: drives the reset pin and pulls the shared pin for sleep
module host_pin_model #(
    parameter int HOLD_CYC = 20
) (
    // control from the bench
    input  wire logic clk_sys,
    input  wire logic start_reset,
    input  wire logic sleep_req,
    // pins
    input  wire logic dut_pin_oe,
    output logic      hw_reset_n,
    output logic      pin_level
);
    int unsigned hold_cnt = 0;

    initial hw_reset_n = 1'b1;

    // the pulse never ends early, even if start_reset drops at once
    always @(posedge clk_sys) begin
        if (start_reset && hold_cnt == 0) begin
            hw_reset_n <= 1'b0;
            hold_cnt   <= HOLD_CYC;
        end else if (hold_cnt == 1) begin
            hw_reset_n <= 1'b1;
            hold_cnt   <= 0;
        end else if (hold_cnt > 1) begin
            hold_cnt <= hold_cnt - 1;
        end
    end

    // pulled up: low whenever either party pulls
    assign pin_level = ~(dut_pin_oe | sleep_req);
endmodule // host_pin_model

// ### verification/rst_pwr_chk.sv
`timescale 1ns/1ns

module rst_pwr_chk #(
    parameter int STRAP_W = 5
) (
    input wire logic               clk_sys,
    input wire logic               reset,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pready,
    input wire logic               hw_reset_n,
    input wire logic               trst_n,
    input wire logic [STRAP_W-1:0] strap_pins,
    input wire logic               irq_or_sleep_pin_in,
    input wire logic               irq_or_sleep_pin_out,
    input wire logic               irq_or_sleep_pin_oe,
    input wire logic               ext_core_supply,
    input wire logic               core_reset,
    input wire logic               test_logic_reset,
    input wire logic [STRAP_W-1:0] strap_cfg,
    input wire logic               power_down,
    input wire logic               regulator_off,
    input wire logic               irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_pin_hold: assert property (
        !hw_reset_n |=> core_reset) else $error("core not held in reset");
    chk_sync_release: assert property (
        $rose(hw_reset_n) |-> core_reset[*4] ##[1:2] !core_reset)
        else $error("core release not after the set delay");
    chk_strap_latch: assert property (
        $rose(hw_reset_n) |-> strap_cfg == $past(strap_pins))
        else $error("straps not sampled during reset");
    chk_strap_hold: assert property (
        !core_reset && hw_reset_n |=> $stable(strap_cfg))
        else $error("straps changed outside reset");
    chk_sleep_cause: assert property (
        power_down |-> $past(irq_or_sleep_pin_in) == 1'b0)
        else $error("power-down without pin low");
    chk_drain_only: assert property (
        irq_or_sleep_pin_oe |-> irq && !irq_or_sleep_pin_out)
        else $error("pin driven without pending interrupt");
    chk_quiet_reset: assert property (
        core_reset |-> !irq_or_sleep_pin_oe && !power_down)
        else $error("pin active while core in reset");
    chk_apb_wait: assert property (
        psel && !penable |=> pready) else $error("no answer after setup");
    chk_trst_async: assert property (
        !trst_n |-> test_logic_reset) else $error("test reset missed");
    chk_trst_release: assert property (
        $rose(trst_n) |-> ##[1:3] !test_logic_reset)
        else $error("test reset stuck");
    chk_reg_supply: assert property (
        regulator_off |-> $past(ext_core_supply))
        else $error("regulator off without external supply");

    cover property ($rose(power_down));
    cover property ($rose(irq_or_sleep_pin_oe));
    cover property ($rose(regulator_off));
endmodule // rst_pwr_chk

////////////////////////////////////////////////////////////////////////////

bind reset_powerdown_interrupt_pin rst_pwr_chk #(.STRAP_W(STRAP_W)) chk_u (
    .clk_sys, .reset, .psel, .penable, .pready, .hw_reset_n, .trst_n,
    .strap_pins, .irq_or_sleep_pin_in, .irq_or_sleep_pin_out,
    .irq_or_sleep_pin_oe, .ext_core_supply, .core_reset, .test_logic_reset,
    .strap_cfg, .power_down, .regulator_off, .irq
);

// ### verification/tb_reset_powerdown_interrupt_pin.sv
`timescale 1ns/1ns
`include "rst_pwr_regs.svh"

module tb_reset_powerdown_interrupt_pin;
    logic        clk_sys    = 1'b0;
    logic        reset      = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [15:0] paddr      = 16'h0000;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic        trst_n     = 1'b1;
    logic [4:0]  strap_pins = 5'h01;
    logic [4:0]  phy_event  = 5'h00;
    logic        ext_supply = 1'b0;
    logic        start_rst  = 1'b0;
    logic        sleep_req  = 1'b0;
    logic        pready, pslverr, hw_reset_n, pin_level, pin_out, pin_oe;
    logic        core_reset, test_logic_reset, power_down, reg_off, irq;
    logic [31:0] prdata;
    logic [4:0]  strap_cfg;
    int          fail_count = 0;
    int          checked    = 0;
    int          cycles     = 0;

    always #25 clk_sys = ~clk_sys;

    reset_powerdown_interrupt_pin dut_u (
        .clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .hw_reset_n, .trst_n, .strap_pins,
        .irq_or_sleep_pin_in(pin_level), .irq_or_sleep_pin_out(pin_out),
        .irq_or_sleep_pin_oe(pin_oe), .phy_event,
        .ext_core_supply(ext_supply), .core_reset, .test_logic_reset,
        .strap_cfg, .power_down, .regulator_off(reg_off), .irq
    );

    host_pin_model host_u (
        .clk_sys, .start_reset(start_rst), .sleep_req,
        .dut_pin_oe(pin_oe), .hw_reset_n, .pin_level
    );

    ////////////////////////////////////////////////////////////////////////

    task automatic conclude();
        $display("checks %0d failures %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no local limit: a slave that never answers runs into the timeout
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        check(n, 32'h0000_0001);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] exp,
                      input logic err = 1'b0);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        chk1(e, err);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
        chk1(e, 1'b0);
    endtask

    task automatic wait_rel();
        int n;
        n = 0;
        while (core_reset !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        tick(2);
    endtask

    task automatic pulse_event(input logic [4:0] ev);
        phy_event <= ev;
        tick(1);
        phy_event <= 5'h00;
        tick(3);
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("[ERR] %0t run did not finish", $time);
            conclude();
        end
    end

    initial begin
        tick(3);
        reset <= 1'b0;
        wait_rel();
        rd(`OFS_CONTROL, 32'h0);
        rd(`OFS_EVENT_STATUS, 32'h4);
        rd(`OFS_EVENT_MASK, 32'h0);
        rd(`OFS_REGULATOR_POWER, 32'h0);
        rd(16'h0010, 32'h0, 1'b1);
        wr(`OFS_EVENT_STATUS, 32'h4);
        sleep_req <= 1'b1;
        tick(2);
        chk1(power_down, 1'b1);
        chk1(pin_oe, 1'b0);
        sleep_req <= 1'b0;
        tick(2);
        chk1(power_down, 1'b0);
        rd(`OFS_EVENT_STATUS, 32'h3);
        wr(`OFS_EVENT_STATUS, 32'h3);
        wr(`OFS_CONTROL, 32'h1);
        wr(`OFS_EVENT_MASK, 32'h8);
        pulse_event(5'h02);
        chk1(pin_level, 1'b1);
        pulse_event(5'h01);
        chk1(irq, 1'b1);
        chk1(pin_level, 1'b0);
        chk1(power_down, 1'b0);
        rd(`OFS_EVENT_STATUS, 32'h18);
        wr(`OFS_EVENT_STATUS, 32'h8);
        tick(2);
        chk1(pin_oe, 1'b0);
        rd(`OFS_EVENT_STATUS, 32'h10);
        wr(`OFS_REGULATOR_POWER, 32'h1);
        ext_supply <= 1'b1;
        tick(3);
        chk1(reg_off, 1'b1);
        rd(`OFS_REGULATOR_POWER, 32'h1);
        ext_supply <= 1'b0;
        tick(3);
        chk1(reg_off, 1'b0);
        // pins move while running; the latched straps must not
        strap_pins <= 5'h15;
        tick(2);
        check({27'h0, strap_cfg}, 32'h1);
        start_rst <= 1'b1;
        tick(1);
        start_rst <= 1'b0;
        tick(3);
        chk1(core_reset, 1'b1);
        wait_rel();
        check({27'h0, strap_cfg}, 32'h15);
        rd(`OFS_CONTROL, 32'h0);
        rd(`OFS_REGULATOR_POWER, 32'h0);
        rd(`OFS_STATE, 32'h0000_1506);
        trst_n <= 1'b0;
        tick(2);
        chk1(test_logic_reset, 1'b1);
        trst_n <= 1'b1;
        tick(4);
        chk1(test_logic_reset, 1'b0);
        conclude();
    end
endmodule // tb_reset_powerdown_interrupt_pin
